// file: verilog/rfm_cfg_regs.v
// Modem configuration register group with AXI4-Lite slave
//
// Overview of operation
// - Received packet addresses are compared with the 8-bit node address, broadcast optional.
// - A 2-bit filter select gives off, node only, node or 0x00, node or 0x00 or 0xFF.
// - The unsigned 8-bit channel index times the channel spacing is added to the base word.
// - The 5-bit IF word in steps of f/2^10 is subtracted in receive and drives the mixer.
// - The signed 8-bit offset in steps of f/2^14 is added to the base before synthesis.
// - The two top bits of the 24-bit frequency word are read-only zero.
// - The base word spans three byte registers and sets the carrier in steps of f/2^16.
// - Bandwidth exponent in bits 7:6 and mantissa in bits 5:4 set the ADC decimation.
// - Symbol rate is (256 + mantissa) times 2^exponent over 2^28, times the crystal clock.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "rfm_cfg_map.vh"
module rfm_cfg_regs (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Packet engine
  input wire [7:0] pkt_addr,
  input wire rx_mode,
  output wire pkt_addr_accept,
  // Modem settings
  output wire [25:0] carrier_word,
  output wire [4:0] intermediate_base_word_a_word,
  output wire [1:0] bandwidth_exponent,
  output wire [1:0] bandwidth_mantissa,
  output wire [3:0] symbol_rate_exponent,
  output wire [8:0] symbol_rate_mantissa_full,
  output reg [5:0] decim_factor_reg,
  output reg [15:0] rate_step_reg
);
  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  reg [7:0] node_address_reg;
  reg [7:0] channel_number_reg;
  reg [7:0] synth_if_control_reg;
  reg [7:0] synth_offset_control_reg;
  reg [7:0] base_base_word_a_high_reg;
  reg [7:0] base_base_word_a_mid_reg;
  reg [7:0] base_base_word_a_low_reg;
  reg [7:0] modem_bw_rate_exp_reg;
  reg [7:0] modem_rate_mantissa_reg;
  reg [1:0] addr_filter_select_reg;
  reg [15:0] channel_spacing_reg;
  reg [7:0] test_addr_reg;

  // --------------------------------------------------------------------
  // Write channel handshake
  // --------------------------------------------------------------------
  reg aw_held_reg;
  reg w_held_reg;
  reg [9:0] aw_idx_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire aw_take;
  wire w_take;
  wire wr_go;
  wire [9:0] wr_idx;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  reg wr_hit;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_go = (aw_held_reg || aw_take) && (w_held_reg || w_take);
  assign wr_idx = aw_held_reg ? aw_idx_reg : s_axi_awaddr[11:2];
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 10'd0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RFM_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RFM_RESP_OKAY : `RFM_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_idx_reg <= s_axi_awaddr[11:2];
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  always @* begin
    case (wr_idx)
      {2'd0, `RFM_IDX_NODE_ADDR}, {2'd0, `RFM_IDX_CHANNEL}, {2'd0, `RFM_IDX_IF_CTRL},
      {2'd0, `RFM_IDX_OFS_CTRL}, {2'd0, `RFM_IDX_BASE_WORD_A_HIGH}, {2'd0, `RFM_IDX_BASE_WORD_A_MID},
      {2'd0, `RFM_IDX_BASE_WORD_A_LOW}, {2'd0, `RFM_IDX_BW_EXP}, {2'd0, `RFM_IDX_RATE_MANT},
      {2'd0, `RFM_IDX_FILTER_CTRL}, {2'd0, `RFM_IDX_FILTER_TEST}: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      node_address_reg <= `RFM_RST_NODE_ADDR;
      channel_number_reg <= `RFM_RST_CHANNEL;
      synth_if_control_reg <= `RFM_RST_IF_CTRL;
      synth_offset_control_reg <= `RFM_RST_OFS_CTRL;
      base_base_word_a_high_reg <= `RFM_RST_BASE_WORD_A_HIGH;
      base_base_word_a_mid_reg <= `RFM_RST_BASE_WORD_A_MID;
      base_base_word_a_low_reg <= `RFM_RST_BASE_WORD_A_LOW;
      modem_bw_rate_exp_reg <= `RFM_RST_BW_EXP;
      modem_rate_mantissa_reg <= `RFM_RST_RATE_MANT;
      addr_filter_select_reg <= `RFM_RST_FILTER;
      test_addr_reg <= `RFM_BCAST_ZERO;
    end else if (wr_go && wr_strb[0]) begin
      case (wr_idx)
        {2'd0, `RFM_IDX_NODE_ADDR}: node_address_reg <= wr_data[7:0];
        {2'd0, `RFM_IDX_CHANNEL}: channel_number_reg <= wr_data[7:0];
        {2'd0, `RFM_IDX_IF_CTRL}:
          synth_if_control_reg <= wr_data[7:0] & `RFM_MASK_IF_CTRL;
        {2'd0, `RFM_IDX_OFS_CTRL}: synth_offset_control_reg <= wr_data[7:0];
        {2'd0, `RFM_IDX_BASE_WORD_A_HIGH}:
          base_base_word_a_high_reg <= wr_data[7:0] & `RFM_MASK_BASE_WORD_A_HIGH;
        {2'd0, `RFM_IDX_BASE_WORD_A_MID}: base_base_word_a_mid_reg <= wr_data[7:0];
        {2'd0, `RFM_IDX_BASE_WORD_A_LOW}: base_base_word_a_low_reg <= wr_data[7:0];
        {2'd0, `RFM_IDX_BW_EXP}: modem_bw_rate_exp_reg <= wr_data[7:0];
        {2'd0, `RFM_IDX_RATE_MANT}: modem_rate_mantissa_reg <= wr_data[7:0];
        {2'd0, `RFM_IDX_FILTER_CTRL}: begin
          addr_filter_select_reg <= wr_data[`RFM_FILT_MSB:0];
        end
        {2'd0, `RFM_IDX_FILTER_TEST}: test_addr_reg <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Channel spacing, upper half of the filter control word
  // --------------------------------------------------------------------
  wire spacing_hit;
  wire spacing_lo_we;
  wire spacing_hi_we;

  assign spacing_hit = wr_go && (wr_idx == {2'd0, `RFM_IDX_FILTER_CTRL});
  assign spacing_lo_we = spacing_hit && wr_strb[`RFM_STRB_SPACE_LO];
  assign spacing_hi_we = spacing_hit && wr_strb[`RFM_STRB_SPACE_HI];

  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_spacing_reg <= `RFM_RST_SPACING;
    end else begin
      if (spacing_lo_we) begin
        channel_spacing_reg[7:0] <= wr_data[`RFM_SPACE_LSB+7:`RFM_SPACE_LSB];
      end
      if (spacing_hi_we) begin
        channel_spacing_reg[15:8] <= wr_data[`RFM_SPACE_LSB+15:`RFM_SPACE_LSB+8];
      end
    end
  end

  // --------------------------------------------------------------------
  // Field views and derived modem settings
  // --------------------------------------------------------------------
  wire test_accept;
  assign intermediate_base_word_a_word = synth_if_control_reg[`RFM_IF_MSB:0];
  assign bandwidth_exponent = modem_bw_rate_exp_reg[`RFM_BWE_MSB:`RFM_BWE_LSB];
  assign bandwidth_mantissa = modem_bw_rate_exp_reg[`RFM_BWM_MSB:`RFM_BWM_LSB];
  assign symbol_rate_exponent = modem_bw_rate_exp_reg[`RFM_DRE_MSB:0];
  assign symbol_rate_mantissa_full = {1'b1, modem_rate_mantissa_reg};

  always @(posedge aclk) begin
    if (!aresetn) begin
      decim_factor_reg <= 6'd0;
      rate_step_reg <= 16'h0000;
    end else begin
      // Divider of f_xosc/8: (4 + m) * 2^e
      decim_factor_reg <= {3'd0, 1'b1, bandwidth_mantissa} << bandwidth_exponent;
      // Multiplier of f_xosc/2^28, shifted left by the exponent downstream
      rate_step_reg <= {7'd0, symbol_rate_mantissa_full};
    end
  end

  // --------------------------------------------------------------------
  // Address filter and synthesizer word
  // --------------------------------------------------------------------
  rfm_addr_filter u_filter (
    .node_address(node_address_reg),
    .addr_filter_select(addr_filter_select_reg),
    .pkt_addr(pkt_addr),
    .accept(pkt_addr_accept)
  );

  rfm_addr_filter u_filter_test (
    .node_address(node_address_reg),
    .addr_filter_select(addr_filter_select_reg),
    .pkt_addr(test_addr_reg),
    .accept(test_accept)
  );

  rfm_synth_calc u_synth (
    .aclk(aclk),
    .aresetn(aresetn),
    .base_word_a({base_base_word_a_high_reg[5:0], base_base_word_a_mid_reg, base_base_word_a_low_reg}),
    .channel_index(channel_number_reg),
    .channel_spacing(channel_spacing_reg),
    .synth_offset_word(synth_offset_control_reg),
    .intermediate_base_word_a_word(intermediate_base_word_a_word),
    .rx_mode(rx_mode),
    .carrier_word_reg(carrier_word)
  );

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_hit;
  wire [9:0] rd_idx;
  assign rd_idx = s_axi_araddr[11:2];
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_idx)
      {2'd0, `RFM_IDX_NODE_ADDR}: rd_mux[7:0] = node_address_reg;
      {2'd0, `RFM_IDX_CHANNEL}: rd_mux[7:0] = channel_number_reg;
      {2'd0, `RFM_IDX_IF_CTRL}: rd_mux[7:0] = synth_if_control_reg;
      {2'd0, `RFM_IDX_OFS_CTRL}: rd_mux[7:0] = synth_offset_control_reg;
      {2'd0, `RFM_IDX_BASE_WORD_A_HIGH}: rd_mux[7:0] = base_base_word_a_high_reg;
      {2'd0, `RFM_IDX_BASE_WORD_A_MID}: rd_mux[7:0] = base_base_word_a_mid_reg;
      {2'd0, `RFM_IDX_BASE_WORD_A_LOW}: rd_mux[7:0] = base_base_word_a_low_reg;
      {2'd0, `RFM_IDX_BW_EXP}: rd_mux[7:0] = modem_bw_rate_exp_reg;
      {2'd0, `RFM_IDX_RATE_MANT}: rd_mux[7:0] = modem_rate_mantissa_reg;
      {2'd0, `RFM_IDX_FILTER_CTRL}: begin
        rd_mux[`RFM_FILT_MSB:0] = addr_filter_select_reg;
        rd_mux[31:`RFM_SPACE_LSB] = channel_spacing_reg;
      end
      {2'd0, `RFM_IDX_FILTER_TEST}: rd_mux = {23'd0, test_accept, test_addr_reg};
      {2'd0, `RFM_IDX_SYNTH_STAT}: rd_mux = {6'd0, carrier_word};
      {2'd0, `RFM_IDX_CARRIER}: rd_mux = {10'd0, decim_factor_reg, rate_step_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RFM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `RFM_RESP_OKAY : `RFM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: verilog/rfm_cfg_map.vh
// Register offsets, field positions and reset values of the modem configuration group
`ifndef RFM_CFG_MAP_VH
`define RFM_CFG_MAP_VH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RFM_IDX_NODE_ADDR 8'h09
`define RFM_IDX_CHANNEL 8'h0a
`define RFM_IDX_IF_CTRL 8'h0b
`define RFM_IDX_OFS_CTRL 8'h0c
`define RFM_IDX_BASE_WORD_A_HIGH 8'h0d
`define RFM_IDX_BASE_WORD_A_MID 8'h0e
`define RFM_IDX_BASE_WORD_A_LOW 8'h0f
`define RFM_IDX_BW_EXP 8'h10
`define RFM_IDX_RATE_MANT 8'h11
`define RFM_IDX_FILTER_CTRL 8'h20
`define RFM_IDX_FILTER_TEST 8'h21
`define RFM_IDX_SYNTH_STAT 8'h22
`define RFM_IDX_CARRIER 8'h23
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RFM_RST_NODE_ADDR 8'h00
`define RFM_RST_CHANNEL 8'h00
`define RFM_RST_IF_CTRL 8'h0f
`define RFM_RST_OFS_CTRL 8'h00
`define RFM_RST_BASE_WORD_A_HIGH 8'h1e
`define RFM_RST_BASE_WORD_A_MID 8'hc4
`define RFM_RST_BASE_WORD_A_LOW 8'hec
`define RFM_RST_BW_EXP 8'h8c
`define RFM_RST_RATE_MANT 8'h22
`define RFM_RST_FILTER 2'b00
`define RFM_RST_SPACING 16'h0000
// ----------------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------------
`define RFM_MASK_IF_CTRL 8'h3f
`define RFM_MASK_BASE_WORD_A_HIGH 8'h3f
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RFM_IF_MSB 4
`define RFM_BWE_MSB 7
`define RFM_BWE_LSB 6
`define RFM_BWM_MSB 5
`define RFM_BWM_LSB 4
`define RFM_DRE_MSB 3
`define RFM_FILT_MSB 1
`define RFM_SPACE_LSB 16
`define RFM_STRB_SPACE_LO 2
`define RFM_STRB_SPACE_HI 3
// ----------------------------------------------------------------------
// Address filter modes and broadcast values
// ----------------------------------------------------------------------
`define RFM_FILT_OFF 2'b00
`define RFM_FILT_NODE 2'b01
`define RFM_FILT_ZERO 2'b10
`define RFM_FILT_BOTH 2'b11
`define RFM_BCAST_ZERO 8'h00
`define RFM_BCAST_ONES 8'hff
// ----------------------------------------------------------------------
// Scaling of the word arithmetic and bus response codes
// ----------------------------------------------------------------------
`define RFM_SH_BASE_TO_OFS 2
`define RFM_SH_IF_TO_BASE 6
`define RFM_RESP_OKAY 2'b00
`define RFM_RESP_SLVERR 2'b10
`endif

// file: verilog/rfm_addr_filter.v
// Received packet address filter
`include "rfm_cfg_map.vh"
module rfm_addr_filter (
  // Settings
  input wire [7:0] node_address,
  input wire [1:0] addr_filter_select,
  // Packet address
  input wire [7:0] pkt_addr,
  // Verdict
  output reg accept
);
  always @* begin
    case (addr_filter_select)
      `RFM_FILT_OFF: accept = 1'b1;
      `RFM_FILT_NODE: accept = (pkt_addr == node_address);
      `RFM_FILT_ZERO: accept = (pkt_addr == node_address) ||
        (pkt_addr == `RFM_BCAST_ZERO);
      `RFM_FILT_BOTH: accept = (pkt_addr == node_address) ||
        (pkt_addr == `RFM_BCAST_ZERO) || (pkt_addr == `RFM_BCAST_ONES);
      default: accept = 1'b0;
    endcase
  end
endmodule

// file: verilog/rfm_synth_calc.v
// Synthesizer frequency word arithmetic, in units of f_xosc / 2^16
`include "rfm_cfg_map.vh"
module rfm_synth_calc (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Settings
  input wire [21:0] base_word_a,
  input wire [7:0] channel_index,
  input wire [15:0] channel_spacing,
  input wire [7:0] synth_offset_word,
  input wire [4:0] intermediate_base_word_a_word,
  input wire rx_mode,
  // Result
  output reg [25:0] carrier_word_reg
);
  reg [25:0] carrier_word_next;
  wire [23:0] channel_index_product;
  wire [25:0] ofs_ext;
  wire [25:0] if_ext;
  assign channel_index_product = channel_index * channel_spacing;
  // Offset step is f/2^14, i.e. four base steps
  assign ofs_ext = {{18{synth_offset_word[7]}}, synth_offset_word} <<< `RFM_SH_BASE_TO_OFS;
  // IF step is f/2^10, i.e. 64 base steps
  assign if_ext = {21'd0, intermediate_base_word_a_word} << `RFM_SH_IF_TO_BASE;
  always @* begin
    carrier_word_next = {4'd0, base_word_a} + {2'd0, channel_index_product};
    carrier_word_next = carrier_word_next + ofs_ext;
    if (rx_mode) begin
      carrier_word_next = carrier_word_next - if_ext;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      carrier_word_reg <= 26'd0;
    end else begin
      carrier_word_reg <= carrier_word_next;
    end
  end
endmodule

// file: verification/rfm_cfg_regs_props.sv
// Concurrent property checker for the modem configuration register group
module rfm_cfg_regs_props (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Modem settings
  input wire rx_mode,
  input wire [25:0] carrier_word,
  input wire [4:0] intermediate_base_word_a_word,
  input wire [1:0] bandwidth_exponent,
  input wire [1:0] bandwidth_mantissa,
  input wire [8:0] symbol_rate_mantissa_full,
  input wire [5:0] decim_factor_reg,
  input wire [15:0] rate_step_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------------
  // Bus handshake and receive-mode steps, bus and modem setting checks
  // ------------------------------------------------------------------
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rx_rise_quiet;
    $past(aresetn) && $past(rx_mode) && !$past(rx_mode, 2) && !s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (aw_w_taken |=> s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data missing");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_bus_blocked: assert property (s_axi_bvalid || s_axi_rvalid |->
    !(s_axi_bvalid && (s_axi_awready || s_axi_wready)) && !(s_axi_rvalid && s_axi_arready))
    else $error("new request taken while answer pending");
  chk_hidden_one: assert property (symbol_rate_mantissa_full[8])
    else $error("symbol rate hidden bit low");
  chk_rate_step: assert property ($past(aresetn) |->
    rate_step_reg == {7'h00, $past(symbol_rate_mantissa_full)})
    else $error("rate step wrong");
  chk_decim_value: assert property ($past(aresetn) |-> decim_factor_reg ==
    ((6'h4 + {4'h0, $past(bandwidth_mantissa)}) << $past(bandwidth_exponent)))
    else $error("decimation factor wrong");
  chk_rx_if_shift: assert property (rx_rise_quiet |-> carrier_word ==
    $past(carrier_word) - {15'h0, $past(intermediate_base_word_a_word), 6'h00})
    else $error("carrier not lowered by IF in receive");
endmodule

bind rfm_cfg_regs rfm_cfg_regs_props rfm_cfg_regs_props_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .rx_mode, .carrier_word, .intermediate_base_word_a_word, .bandwidth_exponent,
  .bandwidth_mantissa, .symbol_rate_mantissa_full, .decim_factor_reg, .rate_step_reg);

// file: verification/rfm_cfg_regs_tb.sv
// Self-checking testbench for the modem configuration register group
module rfm_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, rx_mode = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0] pkt_addr = 8'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire pkt_addr_accept;
  wire [1:0] s_axi_bresp, s_axi_rresp, bandwidth_exponent, bandwidth_mantissa;
  wire [31:0] s_axi_rdata;
  wire [25:0] carrier_word;
  wire [4:0] intermediate_base_word_a_word;
  wire [3:0] symbol_rate_exponent;
  wire [8:0] symbol_rate_mantissa_full;
  wire [5:0] decim_factor_reg;
  wire [15:0] rate_step_reg;
  int fail_count = 0, checks_done = 0;
  logic [31:0] seed = 32'h0000_1970;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [7:0] mdl[9], msk[9], fa[4];
  logic [15:0] spc = 16'h0000;

  rfm_cfg_regs rfm_cfg_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pkt_addr, .rx_mode, .pkt_addr_accept, .carrier_word,
    .intermediate_base_word_a_word, .bandwidth_exponent, .bandwidth_mantissa,
    .symbol_rate_exponent, .symbol_rate_mantissa_full, .decim_factor_reg, .rate_step_reg);

  always #12.5 aclk = ~aclk;
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [33:0] carr();
    logic [25:0] c;
    c = {4'h0, mdl[4][5:0], mdl[5], mdl[6]} + mdl[1] * spc + {{16{mdl[3][7]}}, mdl[3], 2'b00};
    if (rx_mode) c = c - {15'h0, mdl[2][4:0], 6'h00};
    return {8'h00, c};
  endfunction
  function automatic logic [33:0] drt();
    logic [5:0] d;
    d = (6'h4 + {4'h0, mdl[7][5:4]}) << mdl[7][7:6];
    return {12'h000, d, 8'h01, mdl[8]};
  endfunction
  function automatic logic acc(input logic [1:0] m, input logic [7:0] a);
    return m == 2'b00 || a == mdl[0] || (m[1] && a == 8'h00) || (m == 2'b11 && a == 8'hff);
  endfunction
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic da = 1'b0, dw = 1'b0, ta, tw;
    exp_b.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    repeat (rnd() % 4) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    repeat (rnd() % 4) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wrreg(input int k, input logic [31:0] d);
    mdl[k] = d[7:0] & msk[k];
    wr(12'h024 + 12'(4 * k), d, 4'hf, 2'b00);
  endtask
  task automatic rdreg(input int k);
    rd(12'h024 + 12'(4 * k), {26'h0, mdl[k]});
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Response monitor
  // ------------------------------------------------------------------
  always @(negedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) === 1'b1) begin
      cmp({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    end
    if ((s_axi_bvalid && s_axi_bready) === 1'b1) begin
      cmp({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
    end
  end
  // Whole run needs about a thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    finish_test();
  end
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    msk = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};
    mdl = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22};
    fa = '{8'h5a, 8'h00, 8'hff, 8'h33};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 9; k++) rdreg(k);
    rd(12'h080, 34'h0);
    rd(12'h088, carr());
    rd(12'h08c, drt());
    wrreg(2, 32'hffff_ffff);
    wrreg(4, 32'hffff_ffff);
    rdreg(2);
    rdreg(4);
    wr(12'h024, 32'h0000_00aa, 4'h0, 2'b00);
    rdreg(0);
    wr(12'h100, 32'h0000_0001, 4'hf, 2'b10);
    rd(12'h100, {2'b10, 32'h0});
    for (int i = 0; i < 8; i++) begin
      rx_mode <= 1'b0;
      for (int k = 0; k < 9; k++) wrreg(k, rnd());
      if (i == 0) wrreg(1, 32'h0000_00ff);
      if (i == 0) wrreg(3, 32'h0000_0080);
      spc = 16'(rnd());
      wr(12'h080, {spc, 16'h0001}, 4'hf, 2'b00);
      @(posedge aclk);
      rx_mode <= i[0];
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      cmp({8'h00, carrier_word}, carr());
      cmp({12'h000, decim_factor_reg, rate_step_reg}, drt());
      cmp({29'h0, intermediate_base_word_a_word}, {29'h0, mdl[2][4:0]});
      cmp({30'h0, bandwidth_exponent, bandwidth_mantissa}, {30'h0, mdl[7][7:4]});
      cmp({30'h0, symbol_rate_exponent}, {30'h0, mdl[7][3:0]});
      cmp({25'h0, symbol_rate_mantissa_full}, {25'h0, 1'b1, mdl[8]});
      rd(12'h088, carr());
      rd(12'h08c, drt());
      for (int k = 0; k < 9; k++) rdreg(k);
    end
    wrreg(0, 32'h0000_005a);
    for (int m = 0; m < 4; m++) begin
      wr(12'h080, {spc, 14'h0, m[1:0]}, 4'hf, 2'b00);
      rd(12'h080, {2'b00, spc, 14'h0, m[1:0]});
      for (int j = 0; j < 4; j++) begin
        wr(12'h084, {24'h0, fa[j]}, 4'hf, 2'b00);
        pkt_addr <= fa[j];
        @(posedge aclk);
        @(negedge aclk);
        cmp({33'h0, pkt_addr_accept}, {33'h0, acc(m[1:0], fa[j])});
        rd(12'h084, {25'h0, acc(m[1:0], fa[j]), fa[j]});
      end
    end
    finish_test();
  end
endmodule
